// File: watchdog_reset_cause_flag_top.sv
// watchdog_reset_cause_flag_top: watchdog timer with control register, reset-cause flags and
// an axi4-lite register slave.
// assumes reset events arrive as one-cycle pulses from reset logic that
// keeps this block alive, and the core pulses restart/vector signals.
// Notes on behaviour
// - pin reset sets flag, por or zero clears
// - por sets its flag, only zero write clears
// - counter steps on dedicated oscillator ticks
// - timeout raises interrupt or reset per mode
// - interrupt mode interrupts on expiry, wakes sleep
// - reset mode requests system reset on expiry
// - combined mode interrupts first, then resets
// - fuse forces reset mode, enables locked
// - clear enable or prescaler only in window
// - timeouts selectable from shortest to longest
// - clock monitor forces reset mode
// - timeout sets flag, vector entry clears it
// - writing one clears interrupt flag
// - interrupt needs global and watchdog enables
// - change enable self-clears after four cycles
// - watchdog cause flag holds reset enable
// - codes 0..9 double 2048 upward, rest reserved
// - watchdog reset sets its cause flag
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module watchdog_reset_cause_flag_top #(
  parameter int OSC_DIV = watchdog_reset_cause_flag_pkg::OSC_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic por_event,
  input wire logic pin_reset_event,
  input wire logic brownout_event,
  input wire logic always_on_fuse,
  input wire logic clock_monitor_on,
  input wire logic restart_pulse,
  input wire logic vector_taken,
  output logic timeout_irq,
  output logic system_reset_req
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] cause_r;
  logic timeout_interrupt_flag_r;
  logic timeout_interrupt_enable_r;
  logic wde_r;
  logic [3:0] presc_r;
  logic [2:0] chg_cnt_r;
  logic global_ie_r;
  logic [20:0] count_r;
  logic [$clog2(OSC_DIV)-1:0] div_r;
  logic osc_tick;
  logic expire;
  logic [20:0] limit;
  logic wde_eff;
  logic timeout_interrupt_enable_eff;
  logic chg_open;
  logic force_reset;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_cause;
  logic wr_ctrl;
  logic wr_glob;
  logic wr_ok;
  logic [7:0] wd8;
  logic [7:0] ctrl_rd;

  // operating mode seen by the counter and the expiry actions
  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_IRQ,
    MODE_RESET,
    MODE_BOTH
  } watchdog_reset_cause_flag_mode_t;
  watchdog_reset_cause_flag_mode_t mode;
  logic mode_runs;
  logic mode_irqs;
  logic mode_resets;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  // fuse or clock monitor force reset mode and hide the interrupt
  assign force_reset = always_on_fuse | clock_monitor_on;
  assign wde_eff = force_reset | wde_r | cause_r[watchdog_reset_cause_flag_pkg::WDOG_BIT];
  assign timeout_interrupt_enable_eff = timeout_interrupt_enable_r & ~force_reset;
  assign chg_open = chg_cnt_r != 3'd0;
  assign ctrl_rd = {timeout_interrupt_flag_r, timeout_interrupt_enable_eff, presc_r[3], chg_open, wde_eff,
                    presc_r[2:0]};

  // the effective enables pick the mode; the fuse and the clock
  // monitor have already folded into them
  always_comb begin
    mode = MODE_STOPPED;
    case ({wde_eff, timeout_interrupt_enable_eff})
      2'b01: mode = MODE_IRQ;
      2'b10: mode = MODE_RESET;
      2'b11: mode = MODE_BOTH;
      default: mode = MODE_STOPPED;
    endcase
  end

  // combined mode only interrupts on its first expiry; the vector
  // entry then drops it to reset mode for the next one
  always_comb begin
    mode_runs = 1'b1;
    mode_irqs = 1'b0;
    mode_resets = 1'b0;
    case (mode)
      MODE_IRQ: mode_irqs = 1'b1;
      MODE_RESET: mode_resets = 1'b1;
      MODE_BOTH: mode_irqs = 1'b1;
      default: mode_runs = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator tick: stands in for the separate 128 khz source
  assign osc_tick = div_r == ($clog2(OSC_DIV))'(OSC_DIV - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || osc_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // reserved codes fall back to the longest period
  always_comb begin
    if (presc_r > watchdog_reset_cause_flag_pkg::MAX_PRESC) begin
      limit = 21'(watchdog_reset_cause_flag_pkg::BASE_TIMEOUT) << watchdog_reset_cause_flag_pkg::MAX_PRESC;
    end else begin
      limit = 21'(watchdog_reset_cause_flag_pkg::BASE_TIMEOUT) << presc_r;
    end
  end

  assign expire = osc_tick && mode_runs &&
                  (count_r >= limit - 21'd1);

  always_ff @(posedge aclk) begin
    if (!aresetn || restart_pulse || expire) begin
      count_r <= '0;
    end else if (osc_tick && mode_runs) begin
      count_r <= count_r + 21'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r;
  assign wr_cause = wr_go && awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_CAUSE && wstrb_r[0];
  assign wr_ctrl = wr_go && awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_CTRL && wstrb_r[0];
  assign wr_glob = wr_go && awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_GLOBAL && wstrb_r[0];
  assign wr_ok = awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_CAUSE ||
                 awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_CTRL ||
                 awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_GLOBAL ||
                 awaddr_r == watchdog_reset_cause_flag_pkg::ADDR_COUNT;
  assign wd8 = wdata_r[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= watchdog_reset_cause_flag_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? watchdog_reset_cause_flag_pkg::RESP_OKAY : watchdog_reset_cause_flag_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset-cause flags: events win over a software clear; a por also
  // clears the other causes. this block must survive the system reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= 4'h0;
    end else if (por_event) begin
      cause_r <= 4'h1 << watchdog_reset_cause_flag_pkg::POR_BIT;
    end else begin
      if (wr_cause) begin
        cause_r <= cause_r & wd8[3:0];
      end
      if (pin_reset_event) begin
        cause_r[watchdog_reset_cause_flag_pkg::PIN_BIT] <= 1'b1;
      end
      if (brownout_event) begin
        cause_r[watchdog_reset_cause_flag_pkg::BROWN_BIT] <= 1'b1;
      end
      if (expire && mode_resets) begin
        cause_r[watchdog_reset_cause_flag_pkg::WDOG_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // change-enable window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chg_cnt_r <= 3'd0;
    end else if (wr_ctrl && wd8[watchdog_reset_cause_flag_pkg::CHG_BIT] && wd8[watchdog_reset_cause_flag_pkg::WDE_BIT]) begin
      chg_cnt_r <= 3'(watchdog_reset_cause_flag_pkg::CHG_WINDOW);
    end else if (chg_open) begin
      chg_cnt_r <= chg_cnt_r - 3'd1;
    end
  end

  // enables and prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wde_r <= watchdog_reset_cause_flag_pkg::CTRL_RESET[watchdog_reset_cause_flag_pkg::WDE_BIT];
      timeout_interrupt_enable_r <= watchdog_reset_cause_flag_pkg::CTRL_RESET[watchdog_reset_cause_flag_pkg::TIMEOUT_INTERRUPT_ENABLE_BIT];
      presc_r <= watchdog_reset_cause_flag_pkg::PRESC_RESET;
    end else begin
      if (wr_ctrl) begin
        if (!force_reset) begin
          timeout_interrupt_enable_r <= wd8[watchdog_reset_cause_flag_pkg::TIMEOUT_INTERRUPT_ENABLE_BIT];
        end
        // setting is always allowed, clearing only in the window
        if (wd8[watchdog_reset_cause_flag_pkg::WDE_BIT] || (chg_open && !wd8[watchdog_reset_cause_flag_pkg::CHG_BIT])) begin
          wde_r <= wd8[watchdog_reset_cause_flag_pkg::WDE_BIT];
        end
        if (chg_open && !wd8[watchdog_reset_cause_flag_pkg::CHG_BIT]) begin
          presc_r <= {wd8[watchdog_reset_cause_flag_pkg::WDP3_BIT], wd8[2:0]};
        end
      end
      // combined mode: vector entry leaves only the reset enable set
      if (vector_taken && wde_eff && timeout_interrupt_enable_eff) begin
        timeout_interrupt_enable_r <= 1'b0;
      end
    end
  end

  // interrupt flag: set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_interrupt_flag_r <= 1'b0;
    end else if (expire && timeout_interrupt_enable_eff) begin
      timeout_interrupt_flag_r <= 1'b1;
    end else if (vector_taken || (wr_ctrl && wd8[watchdog_reset_cause_flag_pkg::TIMEOUT_INTERRUPT_FLAG_BIT])) begin
      timeout_interrupt_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_ie_r <= 1'b0;
    end else if (wr_glob) begin
      global_ie_r <= wd8[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign timeout_irq = timeout_interrupt_flag_r && timeout_interrupt_enable_eff && global_ie_r;

  // reset requested on expiry unless the interrupt stage goes first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_req <= 1'b0;
    end else begin
      system_reset_req <= expire && mode_resets;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read side
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= watchdog_reset_cause_flag_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= watchdog_reset_cause_flag_pkg::RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        watchdog_reset_cause_flag_pkg::ADDR_CAUSE: s_axi_rdata <= {28'h0, cause_r};
        watchdog_reset_cause_flag_pkg::ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_rd};
        watchdog_reset_cause_flag_pkg::ADDR_GLOBAL: s_axi_rdata <= {31'h0, global_ie_r};
        watchdog_reset_cause_flag_pkg::ADDR_COUNT: s_axi_rdata <= {11'h0, count_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= watchdog_reset_cause_flag_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // watchdog_reset_cause_flag_top

// File: watchdog_reset_cause_flag_pkg.sv
// watchdog_reset_cause_flag_pkg: register map, field positions and timing constants for the
// watchdog with reset-cause flags.
// assumes a 32-bit axi4-lite register bus and a 125 MHz system clock.
package watchdog_reset_cause_flag_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_GLOBAL = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;
  // reset_cause_status fields
  localparam int POR_BIT = 0;
  localparam int PIN_BIT = 1;
  localparam int BROWN_BIT = 2;
  localparam int WDOG_BIT = 3;
  // watchdog_control fields
  localparam int TIMEOUT_INTERRUPT_FLAG_BIT = 7;
  localparam int TIMEOUT_INTERRUPT_ENABLE_BIT = 6;
  localparam int WDP3_BIT = 5;
  localparam int CHG_BIT = 4;
  localparam int WDE_BIT = 3;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] PRESC_RESET = 4'h0;
  // unlock window length in system clock cycles
  localparam int CHG_WINDOW = 4;
  // base timeout in oscillator cycles, code 0; codes double up to 9
  localparam int BASE_TIMEOUT = 2048;
  localparam logic [3:0] MAX_PRESC = 4'h9;
  // oscillator rate and system clock rate
  localparam int OSC_HZ = 128000;
  localparam int CLK_HZ = 125000000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : watchdog_reset_cause_flag_pkg

// File: watchdog_reset_cause_flag_top_asserts.sv
// watchdog_reset_cause_flag_top_asserts: port-level checker for the watchdog block.
// assumes it is bound onto watchdog_reset_cause_flag_top and sees only its ports.
`timescale 1ns/100ps
module watchdog_reset_cause_flag_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic always_on_fuse,
  input wire logic clock_monitor_on,
  input wire logic restart_pulse,
  input wire logic vector_taken,
  input wire logic timeout_irq,
  input wire logic system_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence quiet8;
    !system_reset_req [*8];
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  rst_pulse_a: assert property (
    system_reset_req |=> !system_reset_req)
    else $error("reset request longer than one cycle");
  restart_quiet_a: assert property (
    restart_pulse |-> ##2 quiet8)
    else $error("reset request right after restart");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  busy_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:21] == 11'h0)
    else $error("read bits above the counter not zero");
  fuse_noirq_a: assert property (
    always_on_fuse && $past(always_on_fuse) |-> !timeout_irq)
    else $error("interrupt with fuse set");
  clkmon_noirq_a: assert property (
    clock_monitor_on && $past(clock_monitor_on) |-> !timeout_irq)
    else $error("interrupt in clock monitor use");
  vec_clear_a: assert property (vector_taken |-> ##2 !timeout_irq)
    else $error("vector did not clear interrupt");
endmodule // watchdog_reset_cause_flag_checker

bind watchdog_reset_cause_flag_top watchdog_reset_cause_flag_checker u_chk (.*);

// File: watchdog_reset_cause_flag_core_model.sv
// watchdog_reset_cause_flag_core_model: core software strobes and reset logic beside the watchdog.
// assumes its task is called just after a rising edge of aclk.
`timescale 1ns/100ps
module watchdog_reset_cause_flag_core_model (
  input wire logic aclk,
  input wire logic timeout_irq,
  input wire logic isr_on,
  output logic por_event,
  output logic pin_reset_event,
  output logic brownout_event,
  output logic restart_pulse,
  output logic vector_taken
);
  initial begin
    {restart_pulse, brownout_event, pin_reset_event, por_event} = 4'h0;
    vector_taken = 1'b0;
  end
  // one entry per request, as a real core would take it
  always @(posedge aclk) begin
    vector_taken <= isr_on && timeout_irq && !vector_taken;
  end
  // one-cycle strobe; bit 3 is the restart instruction
  task automatic pulse(input logic [3:0] sel);
    {restart_pulse, brownout_event, pin_reset_event, por_event} <= sel;
    @(posedge aclk);
    {restart_pulse, brownout_event, pin_reset_event, por_event} <= 4'h0;
    @(posedge aclk);
  endtask
endmodule // watchdog_reset_cause_flag_core_model

// File: tb_watchdog_with_reset_flags.sv
// tb_watchdog_with_reset_flags: directed tests of the watchdog block.
// assumes watchdog_reset_cause_flag_top, the core model and the bound checker are compiled.
`timescale 1ns/100ps
module tb_watchdog_with_reset_flags;
  localparam int DIV = 4;
  localparam int T0 = 2048 * DIV;
  localparam logic [3:0] CA = watchdog_reset_cause_flag_pkg::ADDR_CAUSE;
  localparam logic [3:0] CT = watchdog_reset_cause_flag_pkg::ADDR_CTRL;
  localparam logic [3:0] GL = watchdog_reset_cause_flag_pkg::ADDR_GLOBAL;
  logic aclk = 0, aresetn = 0, isr_on = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic always_on_fuse = 0, clock_monitor_on = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic por_event, pin_reset_event, brownout_event, restart_pulse;
  logic vector_taken, timeout_irq, system_reset_req;
  int n_errors = 0, n_tests = 0;
  watchdog_reset_cause_flag_top #(.OSC_DIV(DIV)) u_dut (.*);
  watchdog_reset_cause_flag_core_model u_core (.*);
  always #4 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ready is looked at mid-cycle so the edge decision never races
  task automatic bus(input bit w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] q);
    bit ta, tw, tr, dn;
    dn = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      q = w ? {30'h0, s_axi_bresp} : s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tr) s_axi_arvalid <= 0;
      if (dn) s_axi_bready <= 0;
      if (dn) s_axi_rready <= 0;
    end
    // one edge between transfers so ready is never assigned twice at once
    @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
    chk(q, {30'h0, watchdog_reset_cause_flag_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(0, a, 8'h0, q);
    chk(q, {24'h0, e});
  endtask
  task automatic irq_is(input logic e);
    @(negedge aclk);
    chk({31'h0, timeout_irq}, {31'h0, e});
    @(posedge aclk);
  endtask
  // expiry must land within two oscillator ticks of t
  task automatic wait_ev(input bit r, input int t);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!(r ? system_reset_req : timeout_irq) && n < 3 * t);
    chk(32'(n > t - 8 && n < t + 8), 32'h1);
    @(posedge aclk);
  endtask
  ////////////////////////////////////////
  task automatic t_causes();
    rd(CA, 8'h00);
    u_core.pulse(4'h2);
    rd(CA, 8'h02);
    u_core.pulse(4'h1);
    rd(CA, 8'h01);
    u_core.pulse(4'h4);
    rd(CA, 8'h05);
    s_axi_wstrb <= 4'he;
    wr(CA, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd(CA, 8'h05);
    wr(CA, 8'h00);
    rd(CA, 8'h00);
    $display("causes test done");
  endtask
  task automatic t_irq();
    wr(GL, 8'h01);
    wr(CT, 8'h40);
    u_core.pulse(4'h8);
    repeat (T0 / 2) @(posedge aclk);
    u_core.pulse(4'h8);
    wait_ev(0, T0);
    wr(GL, 8'h00);
    irq_is(0);
    wr(GL, 8'h01);
    irq_is(1);
    wr(CT, 8'h40);
    irq_is(1);
    wr(CT, 8'hc0);
    irq_is(0);
    rd(CT, 8'h40);
    $display("interrupt test done");
  endtask
  task automatic t_comb();
    isr_on <= 1;
    wr(CT, 8'h48);
    u_core.pulse(4'h8);
    wait_ev(0, T0);
    repeat (4) @(posedge aclk);
    irq_is(0);
    rd(CT, 8'h08);
    u_core.pulse(4'h8);
    wait_ev(1, T0);
    isr_on <= 0;
    rd(CA, 8'h08);
    u_core.pulse(4'h8);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CA, 8'h00);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rd(CT, 8'h00);
    $display("combined test done");
  endtask
  task automatic t_unlock();
    wr(CT, 8'h08);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    repeat (5) @(posedge aclk);
    rd(CT, 8'h08);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h21);
    rd(CT, 8'h21);
    wr(CT, 8'h18);
    wr(CT, 8'h09);
    u_core.pulse(4'h8);
    wait_ev(1, 2 * T0);
    always_on_fuse <= 1;
    clock_monitor_on <= 1;
    wr(CT, 8'h40);
    rd(CT, 8'h09);
    always_on_fuse <= 0;
    clock_monitor_on <= 0;
    $display("unlock test done");
  endtask
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_causes();
    t_irq();
    t_comb();
    t_unlock();
    report_and_stop();
  end
  initial begin
    repeat (10 * T0) @(posedge aclk);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    report_and_stop();
  end
endmodule // tb_watchdog_with_reset_flags
